// [verilog/codec_host_pkg.sv]
/*
  Constants, field layouts and carrier types of the codec host register port.
  Assumes a host that issues one-cycle read or write strobes synchronous to mclk_i.
*/
package codec_host_pkg;
  localparam logic [3:0] OFS_INDEX = 4'h0;
  localparam logic [3:0] OFS_DATA = 4'h4;
  localparam logic [3:0] OFS_STREAM = 4'h8;
  localparam logic [3:0] OFS_IRQ = 4'hc;
  localparam logic [15:0] IDX_MODE = 16'h0000;
  localparam logic [15:0] IDX_WIN_FIRST = 16'h0002;
  localparam logic [15:0] IDX_WIN_LAST = 16'h0006;
  localparam logic [15:0] IDX_STAT_FIRST = 16'h0080;
  localparam logic [15:0] IDX_STAT_LAST = 16'h00b2;
  localparam logic [15:0] IDX_STEP_FIRST = 16'h0100;
  localparam logic [15:0] IDX_STEP_LAST = 16'h0153;
  localparam int WIN_REGS = 5;
  localparam int STAT_REGS = 51;
  localparam int STEP_REGS = 84;
  localparam int FIFO_WORDS = 512;
  localparam int STOP_MARGIN = 32;
  localparam int SRQ_MARGIN = 128;
  localparam int HUFF_TABLES = 3;
  localparam logic [15:0] MODE_RESET = 16'h0880;
  localparam logic [15:0] INDEX_RESET = 16'h0000;
  localparam logic [6:0] MASK_RESET = 7'h00;
  localparam int MODE_ENCODE_BIT = 7;
  localparam int MODE_SWR_BIT = 11;
  localparam int STATUS_SRQ_BIT = 3;
  localparam int STATUS_STOP_BIT = 5;
  localparam logic [3:0] BE_FULL = 4'hf;
  localparam logic [3:0] BE_LOW = 4'h3;
  localparam logic [3:0] BE_HIGH = 4'hc;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic we;
    logic [5:0] idx;
    logic [15:0] data;
  } stat_wr_t;

  typedef struct packed {
    logic we;
    logic [6:0] idx;
    logic [15:0] data;
  } step_wr_t;

  typedef enum logic [2:0] {
    REG_NONE = 3'b000,
    REG_MODE = 3'b001,
    REG_WIN = 3'b010,
    REG_STAT = 3'b011,
    REG_STEP = 3'b100
  } region_t;

  typedef enum logic {
    HALF_LOW = 1'b0,
    HALF_HIGH = 1'b1
  } half_t;
endpackage

// [verilog/stream_fifo.sv]
/*
  Word FIFO with valid/ready on both sides and a fill level output.
  Assumes DEPTH is a power of two so the pointers wrap by themselves.
*/
`timescale 1ns/1ps
module stream_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 512,
  localparam int AW = $clog2(DEPTH)
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [AW:0] level_o
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic push;
  logic pop;

  assign in_ready_o = count_ff != (AW+1)'(DEPTH);
  assign out_valid_o = count_ff != '0;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr_ff];
  assign level_o = count_ff;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  fifo_count_a: assert property (push && !pop |=> count_ff == $past(count_ff) + 1'b1)
    else $error("fifo level did not rise on push");
  fifo_bound_a: assert property (count_ff <= (AW+1)'(DEPTH))
    else $error("fifo level beyond depth");
endmodule

// [verilog/codec_host_port.sv]
/*
  Host register port of the codec: index pointer, indexed data port,
  compressed stream port with its buffer, mask/status word.
  Assumes host strobes are synchronous one-cycle pulses and that the
  coding core drives the statistics, step and stream ports.
*/
`timescale 1ns/1ps
module codec_host_port #(
  parameter int FIFO_DEPTH = codec_host_pkg::FIFO_WORDS,
  localparam int LW = $clog2(FIFO_DEPTH) + 1
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire codec_host_pkg::host_req_t host_req_i,
  output logic [31:0] host_rdata_o,
  output logic host_ack_o,
  output logic [15:0] mode_o,
  output logic [codec_host_pkg::WIN_REGS-1:0][15:0] window_o,
  input wire codec_host_pkg::stat_wr_t stat_wr_i,
  input wire codec_host_pkg::step_wr_t step_wr_i,
  input wire logic [6:0] step_rd_idx_i,
  output logic [15:0] step_rd_data_o,
  input wire logic [31:0] enc_word_i,
  input wire logic enc_valid_i,
  output logic enc_ready_o,
  output logic [31:0] dec_word_o,
  output logic dec_valid_o,
  input wire logic dec_ready_i,
  output logic fifo_stop_o,
  output logic fifo_srq_o
);
  import codec_host_pkg::*;

  localparam logic [LW-1:0] LVL_FULL_LESS2 = LW'(FIFO_DEPTH - 2);
  localparam logic [LW-1:0] LVL_STOP = LW'(FIFO_DEPTH - STOP_MARGIN);
  localparam logic [LW-1:0] LVL_SRQ_ENC = LW'(FIFO_DEPTH - SRQ_MARGIN);
  localparam logic [LW-1:0] LVL_SRQ_DEC = LW'(SRQ_MARGIN);

  function automatic region_t region_of(input logic [15:0] idx);
    region_t r;
    r = REG_NONE;
    if (idx == IDX_MODE) begin
      r = REG_MODE;
    end else if (idx >= IDX_WIN_FIRST && idx <= IDX_WIN_LAST) begin
      r = REG_WIN;
    end else if (idx >= IDX_STAT_FIRST && idx <= IDX_STAT_LAST) begin
      r = REG_STAT;
    end else if (idx >= IDX_STEP_FIRST && idx <= IDX_STEP_LAST) begin
      r = REG_STEP;
    end
    return r;
  endfunction

  logic [15:0] index_ff;
  logic [15:0] mode_ff;
  logic [WIN_REGS-1:0][15:0] win_ff;
  logic [15:0] stat_mem [STAT_REGS];
  logic [15:0] step_mem [STEP_REGS];
  logic [6:0] mask_ff;
  half_t half_ff;
  half_t nxt_half;
  logic [15:0] low_hold_ff;
  logic [31:0] rdata_ff;
  logic ack_ff;
  logic enc_ready_ff;
  logic [31:0] dec_word_ff;
  logic dec_valid_ff;
  logic stop_ff;
  logic srq_ff;
  logic [15:0] step_rd_ff;

  logic encode;
  logic swr;
  logic index_wr;
  logic data_acc;
  logic data_wr;
  logic data_rd;
  region_t region;
  logic [15:0] win_off_full;
  logic [15:0] stat_off_full;
  logic [15:0] step_off_full;
  logic [2:0] win_off;
  logic [5:0] stat_off;
  logic [6:0] step_off;
  logic [15:0] ind_rdata;
  logic stream_acc;
  logic stream_wr;
  logic stream_rd;
  logic half_closing;
  logic host_push;
  logic host_pop;
  logic [31:0] push_word;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [31:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [31:0] fifo_head;
  logic [LW-1:0] fifo_level;
  logic dec_load;
  logic core_step_we;

  assign encode = mode_ff[MODE_ENCODE_BIT];
  assign swr = mode_ff[MODE_SWR_BIT];
  // settings enter here, except the mask written at OFS_IRQ; the core also writes the statistics, and in decode the step registers
  assign index_wr = host_req_i.wr && host_req_i.addr == OFS_INDEX;
  assign data_wr = host_req_i.wr && host_req_i.addr == OFS_DATA;
  assign data_rd = host_req_i.rd && host_req_i.addr == OFS_DATA;
  assign data_acc = data_wr || data_rd;
  assign region = region_of(index_ff);
  assign win_off_full = index_ff - IDX_WIN_FIRST;
  assign stat_off_full = index_ff - IDX_STAT_FIRST;
  assign step_off_full = index_ff - IDX_STEP_FIRST;
  assign win_off = win_off_full[2:0];
  assign stat_off = stat_off_full[5:0];
  assign step_off = step_off_full[6:0];

  // mode is write-only; unmapped and reserved indices read zero
  always_comb begin
    ind_rdata = '0;
    case (region)
      REG_WIN: ind_rdata = win_ff[win_off];
      REG_STAT: ind_rdata = stat_mem[stat_off];
      REG_STEP: ind_rdata = step_mem[step_off];
      default: ind_rdata = '0;
    endcase
  end

  // index pointer: reset to 0000h, the mode index; loaded by the host, advanced by one on each data access
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      index_ff <= INDEX_RESET;
    end else if (index_wr) begin
      index_ff <= host_req_i.wdata[15:0];
    end else if (data_acc) begin
      index_ff <= index_ff + 16'h0001;
    end
  end

  // mode comes up with software reset held and encode selected;
  // the host still rewrites it after every reset
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_ff <= MODE_RESET;
    end else if (data_wr && region == REG_MODE) begin
      mode_ff <= host_req_i.wdata[15:0];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      win_ff <= '0;
    end else if (data_wr && region == REG_WIN) begin
      win_ff[win_off] <= host_req_i.wdata[15:0];
    end
  end

  // statistics are filled by the core only; host writes there are dropped
  always_ff @(posedge mclk_i) begin
    if (stat_wr_i.we && 32'(stat_wr_i.idx) < STAT_REGS) begin
      stat_mem[stat_wr_i.idx] <= stat_wr_i.data;
    end
  end

  // in decode the step pairs come out of the stream, not from a calculator
  assign core_step_we = step_wr_i.we && !encode && 32'(step_wr_i.idx) < STEP_REGS;

  always_ff @(posedge mclk_i) begin
    if (core_step_we) begin
      step_mem[step_wr_i.idx] <= step_wr_i.data;
    end
    if (data_wr && region == REG_STEP) begin
      step_mem[step_off] <= host_req_i.wdata[15:0];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step_rd_ff <= '0;
    end else if (32'(step_rd_idx_i) < STEP_REGS) begin
      step_rd_ff <= step_mem[step_rd_idx_i];
    end else begin
      step_rd_ff <= '0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_ff <= MASK_RESET;
    end else if (host_req_i.wr && host_req_i.addr == OFS_IRQ) begin
      mask_ff <= host_req_i.wdata[14:8];
    end
  end

  // stream port: decode fills from the host, encode drains to the host
  assign stream_acc = (host_req_i.rd || host_req_i.wr) && host_req_i.addr == OFS_STREAM;
  assign stream_wr = stream_acc && host_req_i.wr && !encode;
  assign stream_rd = stream_acc && host_req_i.rd && encode;
  // a lone high half without its low half moves nothing
  assign half_closing = host_req_i.be == BE_FULL || (host_req_i.be == BE_HIGH && half_ff == HALF_HIGH);
  assign host_push = stream_wr && half_closing;
  assign host_pop = stream_rd && half_closing && fifo_out_valid;
  assign push_word = (host_req_i.be == BE_FULL) ? host_req_i.wdata : {host_req_i.wdata[31:16], low_hold_ff};

  always_comb begin
    nxt_half = half_ff;
    case (half_ff)
      HALF_LOW: begin
        if (stream_acc && host_req_i.be == BE_LOW) begin
          nxt_half = HALF_HIGH;
        end
      end
      HALF_HIGH: begin
        if (stream_acc && (host_req_i.be == BE_HIGH || host_req_i.be == BE_FULL)) begin
          nxt_half = HALF_LOW;
        end
      end
      default: nxt_half = HALF_LOW;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      half_ff <= HALF_LOW;
      low_hold_ff <= '0;
    end else begin
      half_ff <= nxt_half;
      if (stream_wr && host_req_i.be == BE_LOW) begin
        low_hold_ff <= host_req_i.wdata[15:0];
      end
    end
  end

  // words from the core arrive already zero-run and table coded
  assign fifo_in_valid = encode ? (enc_valid_i && enc_ready_ff) : host_push;
  assign fifo_in_data = encode ? enc_word_i : push_word;
  assign dec_load = !encode && !swr && fifo_out_valid && (!dec_valid_ff || dec_ready_i);
  assign fifo_out_ready = encode ? host_pop : dec_load;

  stream_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_head),
    .level_o(fifo_level)
  );

  // ready is registered, so leave one slot of slack for the lag
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enc_ready_ff <= 1'b0;
    end else begin
      enc_ready_ff <= encode && !swr && fifo_level <= LVL_FULL_LESS2;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dec_valid_ff <= 1'b0;
      dec_word_ff <= '0;
    end else if (dec_load) begin
      dec_valid_ff <= 1'b1;
      dec_word_ff <= fifo_head;
    end else if (dec_ready_i || encode) begin
      dec_valid_ff <= 1'b0;
    end
  end

  // decode stop fires early: a margin of free words is still writable
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stop_ff <= 1'b0;
      srq_ff <= 1'b0;
    end else if (encode) begin
      stop_ff <= fifo_level == '0;
      srq_ff <= fifo_level >= LVL_SRQ_ENC;
    end else begin
      stop_ff <= fifo_level >= LVL_STOP;
      srq_ff <= fifo_level <= LVL_SRQ_DEC;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= '0;
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= host_req_i.rd || host_req_i.wr;
      if (host_req_i.rd) begin
        case (host_req_i.addr)
          OFS_DATA: rdata_ff <= {16'h0000, ind_rdata};
          OFS_STREAM: rdata_ff <= (encode && fifo_out_valid) ? fifo_head : 32'h0000_0000;
          OFS_IRQ: begin
            rdata_ff <= '0;
            rdata_ff[14:8] <= mask_ff;
            rdata_ff[STATUS_SRQ_BIT] <= srq_ff;
            rdata_ff[STATUS_STOP_BIT] <= stop_ff;
          end
          default: rdata_ff <= '0; // index pointer is write-only
        endcase
      end
    end
  end

  assign host_rdata_o = rdata_ff;
  assign host_ack_o = ack_ff;
  assign mode_o = mode_ff;
  assign window_o = win_ff;
  assign step_rd_data_o = step_rd_ff;
  assign enc_ready_o = enc_ready_ff;
  assign dec_word_o = dec_word_ff;
  assign dec_valid_o = dec_valid_ff;
  assign fifo_stop_o = stop_ff;
  assign fifo_srq_o = srq_ff;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence low_wr_s;
    host_req_i.wr && host_req_i.addr == OFS_STREAM && host_req_i.be == BE_LOW && !encode;
  endsequence

  sequence high_wr_s;
    host_req_i.wr && host_req_i.addr == OFS_STREAM && host_req_i.be == BE_HIGH && !encode;
  endsequence

  index_load_a: assert property (index_wr |=> index_ff == $past(host_req_i.wdata[15:0]))
    else $error("index pointer not loaded");
  index_step_a: assert property (data_acc && !index_wr |=> index_ff == $past(index_ff) + 16'h0001)
    else $error("index pointer did not advance");
  reserved_zero_a: assert property (data_rd |=> host_ack_o && host_rdata_o[31:16] == 16'h0000)
    else $error("reserved upper bits not zero");
  mode_write_a: assert property (data_wr && region == REG_MODE |=> mode_o == $past(host_req_i.wdata[15:0]))
    else $error("mode not written through data port");
  step_readback_a: assert property (data_wr && region == REG_STEP
    |=> step_mem[$past(step_off)] == $past(host_req_i.wdata[15:0]))
    else $error("step factor readback mismatch");
  stat_read_a: assert property (data_rd && region == REG_STAT |=> host_rdata_o[15:0] == $past(ind_rdata))
    else $error("statistics word not returned");
  half_pair_a: assert property (high_wr_s |-> host_push == (half_ff == HALF_HIGH && fifo_in_ready))
    else $error("high half did not advance buffer");
  low_hold_a: assert property (low_wr_s |-> !host_push ##1 half_ff == HALF_HIGH)
    else $error("low half advanced buffer");
  enc_safe_a: assert property (enc_valid_i && enc_ready_o |-> fifo_in_ready)
    else $error("encode word offered to a full buffer");
  core_step_a: assert property (core_step_we && !(data_wr && region == REG_STEP)
    |=> step_mem[$past(step_wr_i.idx)] == $past(step_wr_i.data))
    else $error("stream step factor not stored");
endmodule

// [test/host_model.sv]
/*
  Behavioural host processor on the register port: one request per call.
  Assumes the testbench calls xfer from a single process.
*/
`timescale 1ns/1ps
module host_model
  import codec_host_pkg::*;
(
  input wire logic mclk_i,
  output host_req_t req_o,
  input wire logic [31:0] rdata_i,
  input wire logic ack_i
);
  initial req_o = '0;

  // strobe is a one-cycle pulse; address, enables and data stay until the answer
  task automatic xfer(input logic rd, input logic [3:0] a, input logic [3:0] be,
      input logic [31:0] d, output logic [31:0] q, output logic ok);
    int n;
    n = 0;
    @(posedge mclk_i);
    // reserved upper half of the index and data ports always sent as zero
    req_o <= '{rd: rd, wr: !rd, addr: a, be: be,
               wdata: (a == OFS_STREAM) ? d : {16'h0000, d[15:0]}};
    @(posedge mclk_i);
    req_o.rd <= 1'b0;
    req_o.wr <= 1'b0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 4);
    q = rdata_i;
    ok = (ack_i === 1'b1);
  endtask
endmodule

// [test/tb_top.sv]
/*
  Self-checking bench of the codec host register port.
  Assumes the host_model partner and a buffer shrunk to 64 words.
*/
`timescale 1ns/1ps
module tb_top;
  import codec_host_pkg::*;
  localparam int DEPTH = 64;
  logic mclk_i;
  logic rst_n_i = 1'b0;
  host_req_t host_req;
  logic [31:0] host_rdata;
  logic host_ack;
  logic [15:0] mode;
  logic [WIN_REGS-1:0][15:0] window;
  stat_wr_t stat_wr = '0;
  step_wr_t step_wr = '0;
  logic [15:0] s;
  logic [6:0] step_rd_idx = '0;
  logic [15:0] step_rd_data;
  logic [31:0] enc_word = '0;
  logic enc_valid = 1'b0;
  logic enc_ready;
  logic [31:0] dec_word;
  logic dec_valid;
  logic dec_ready = 1'b0;
  logic fifo_stop;
  logic fifo_srq;
  int errors = 0;
  int checked = 0;
  logic [15:0] lf = 16'h0c8d;
  logic [31:0] rd;
  logic [31:0] d;
  logic [15:0] v [6];
  logic [31:0] exp_q [$];

  host_model host (.mclk_i(mclk_i), .req_o(host_req), .rdata_i(host_rdata), .ack_i(host_ack));

  codec_host_port #(.FIFO_DEPTH(DEPTH)) dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .host_req_i(host_req), .host_rdata_o(host_rdata),
    .host_ack_o(host_ack), .mode_o(mode), .window_o(window), .stat_wr_i(stat_wr),
    .step_wr_i(step_wr), .step_rd_idx_i(step_rd_idx), .step_rd_data_o(step_rd_data),
    .enc_word_i(enc_word), .enc_valid_i(enc_valid), .enc_ready_o(enc_ready),
    .dec_word_o(dec_word), .dec_valid_o(dec_valid), .dec_ready_i(dec_ready),
    .fifo_stop_o(fifo_stop), .fifo_srq_o(fifo_srq));

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [3:0] be, input logic [31:0] x);
    logic [31:0] q;
    logic ok;
    host.xfer(1'b0, a, be, x, q, ok);
    chk({31'h0, ok}, 32'h1);
  endtask

  task automatic rdr(input logic [3:0] a, input logic [3:0] be, output logic [31:0] q);
    logic ok;
    host.xfer(1'b1, a, be, 32'h0, q, ok);
    chk({31'h0, ok}, 32'h1);
  endtask

  // far side stalls a few cycles before taking each word
  task automatic pop(input logic [31:0] e);
    int n;
    n = 0;
    repeat (3) @(posedge mclk_i);
    while (dec_valid !== 1'b1 && n < 100) begin
      @(posedge mclk_i);
      n++;
    end
    chk({31'h0, dec_valid}, 32'h1);
    chk(dec_word, e);
    dec_ready <= 1'b1;
    @(posedge mclk_i);
    dec_ready <= 1'b0;
  endtask

  task automatic push_enc(input logic [31:0] x);
    int n;
    n = 0;
    while (enc_ready !== 1'b1 && n < 100) begin
      @(posedge mclk_i);
      n++;
    end
    chk({31'h0, enc_ready}, 32'h1);
    enc_word <= x;
    enc_valid <= 1'b1;
    @(posedge mclk_i);
    enc_valid <= 1'b0;
    // one idle edge keeps a second call from raising valid in this time step
    @(posedge mclk_i);
  endtask

  // core writes a step factor at index 5; e is what the table must then hold
  task automatic core_step(input logic [15:0] x, input logic [15:0] e);
    @(posedge mclk_i);
    step_wr <= '{1'b1, 7'h05, x};
    step_rd_idx <= 7'h05;
    @(posedge mclk_i);
    step_wr.we <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk({16'h0000, step_rd_data}, {16'h0000, e});
  endtask

  task automatic conclude;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #400us;
    errors++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    wr(OFS_INDEX, BE_FULL, {16'h0000, IDX_MODE});
    wr(OFS_DATA, BE_FULL, {16'h0000, MODE_RESET});
    #1 chk({16'h0000, mode}, 32'h0000_0880);
    rdr(OFS_INDEX, BE_FULL, rd);
    chk(rd, 32'h0);
    $display("test mode done");
    wr(OFS_INDEX, BE_FULL, {16'h0000, IDX_WIN_FIRST});
    for (int i = 0; i < WIN_REGS; i++) begin
      v[i] = rnd();
      wr(OFS_DATA, BE_FULL, {rnd(), v[i]});
    end
    #1;
    for (int i = 0; i < WIN_REGS; i++) chk({16'h0000, window[i]}, {16'h0000, v[i]});
    $display("test window done");
    wr(OFS_INDEX, BE_FULL, {16'h0000, IDX_STEP_FIRST});
    for (int i = 0; i < 4; i++) begin
      v[i] = rnd();
      wr(OFS_DATA, BE_FULL, {16'h0000, v[i]});
    end
    wr(OFS_INDEX, BE_FULL, {16'h0000, IDX_STEP_FIRST});
    for (int i = 0; i < 4; i++) begin
      rdr(OFS_DATA, BE_FULL, rd);
      chk(rd, {16'h0000, v[i]});
    end
    @(posedge mclk_i);
    step_rd_idx <= 7'h01;
    repeat (2) @(posedge mclk_i);
    #1 chk({16'h0000, step_rd_data}, {16'h0000, v[1]});
    wr(OFS_INDEX, BE_FULL, 32'h0000_0007);
    rdr(OFS_DATA, BE_FULL, rd);
    chk(rd, 32'h0);
    $display("test step done");
    for (int j = 0; j < 2; j++) begin
      v[5] = rnd();
      @(posedge mclk_i);
      stat_wr <= '{1'b1, 6'(j * 50), v[5]};
      @(posedge mclk_i);
      stat_wr.we <= 1'b0;
      wr(OFS_INDEX, BE_FULL, {16'h0000, IDX_STAT_FIRST + 16'(j * 50)});
      rdr(OFS_DATA, BE_FULL, rd);
      chk(rd, {16'h0000, v[5]});
    end
    $display("test stat done");
    wr(OFS_INDEX, BE_FULL, {16'h0000, IDX_MODE});
    wr(OFS_DATA, BE_FULL, 32'h0);
    s = rnd();
    core_step(s, s);
    // the output stage holds one word beyond the buffer; the word after that is lost
    for (int i = 0; i <= DEPTH + 1; i++) begin
      d = {rnd(), rnd()};
      if (i <= DEPTH) exp_q.push_back(d);
      wr(OFS_STREAM, BE_FULL, d);
    end
    chk({31'h0, fifo_stop}, 32'h1);
    while (exp_q.size() > 0) pop(exp_q.pop_front());
    repeat (4) @(posedge mclk_i);
    chk({31'h0, dec_valid}, 32'h0);
    chk({31'h0, fifo_srq}, 32'h1);
    d = {rnd(), rnd()};
    wr(OFS_STREAM, BE_LOW, {16'h0000, d[15:0]});
    repeat (3) @(posedge mclk_i);
    chk({31'h0, dec_valid}, 32'h0);
    wr(OFS_STREAM, BE_HIGH, {d[31:16], 16'h0000});
    pop(d);
    $display("test decode done");
    wr(OFS_INDEX, BE_FULL, {16'h0000, IDX_MODE});
    wr(OFS_DATA, BE_FULL, 32'h0000_0080);
    #1 chk({16'h0000, mode}, 32'h0000_0080);
    core_step(~s, s);
    for (int i = 0; i < 3; i++) begin
      exp_q.push_back({rnd(), rnd()});
      push_enc(exp_q[i]);
    end
    rdr(OFS_STREAM, BE_FULL, rd);
    chk(rd, exp_q[0]);
    rdr(OFS_STREAM, BE_LOW, rd);
    chk({16'h0000, rd[15:0]}, {16'h0000, exp_q[1][15:0]});
    rdr(OFS_STREAM, BE_HIGH, rd);
    chk({16'h0000, rd[31:16]}, {16'h0000, exp_q[1][31:16]});
    rdr(OFS_STREAM, BE_FULL, rd);
    chk(rd, exp_q[2]);
    rdr(OFS_STREAM, BE_FULL, rd);
    chk(rd, 32'h0);
    repeat (2) @(posedge mclk_i);
    chk({31'h0, fifo_stop}, 32'h1);
    $display("test encode done");
    conclude();
  end
endmodule
